// *** crf_regs.sv ***
// programmer visible register set and condition flags of the cpu core
`timescale 1ns/1ps
module crf_regs (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire crf_pkg::crf_cmd_t i_cmd,
	input wire logic i_irq_req,
	input wire logic i_trap_req,
	input wire logic [7:0] i_stk_rdata,
	output crf_pkg::crf_view_t o_view,
	output logic o_busy_q,
	output logic o_taken_q,
	output logic o_irq_enter_q,
	output logic o_trap_enter_q,
	output logic o_stk_wr_q,
	output logic o_stk_rd_q,
	output logic [7:0] o_stk_wdata_q
);
	import crf_pkg::*;

	// ****************************************
	// state
	// ****************************************
	// no reset on data registers: they hold whatever they powered up with
	logic [7:0] acc_q;
	logic [7:0] x_q;
	logic [7:0] y_q;
	logic [7:0] pcl_q;
	logic [7:0] pch_q;
	logic half_q;
	logic neg_q;
	logic zero_q;
	logic carry_q;
	logic mask_q;
	logic irq_pend_q;
	logic trap_pend_q;
	logic busy_q;
	logic interrupt_return_instr_q;
	logic [2:0] rd_idx_q;
	logic rd_act_q;
	logic [2:0] ld_idx_q;

	// ****************************************
	// command decode
	// ****************************************
	logic acc_ok;
	logic is_alu;
	logic [7:0] alu_src;
	logic [7:0] cc_w;
	logic [15:0] pc_w;
	logic [15:0] pc_inc;
	logic cond_ok;
	logic take_any;
	logic take_trap;
	logic start_push;
	logic start_pop;
	logic seq_wr;
	logic seq_rd;
	logic [2:0] seq_idx;
	logic push_done;
	logic pop_done;
	logic rd_req;
	logic [2:0] rd_idx;
	logic ld_cc;
	logic ld_any;
	logic stk_wr;
	logic [7:0] stk_wdata;
	crf_alu_out_t alu_o;

	// condition test shared by jumps and the taken flag; mask test reads the mask
	function automatic logic crf_test(input crf_cond_t c, input logic [7:0] cc);
		logic r;
		r = 1'b1;
		case (c)
			CRF_CND_HALF: r = cc[CRF_H_BIT];
			CRF_CND_NO_HALF: r = ~cc[CRF_H_BIT];
			CRF_CND_MASKED: r = cc[CRF_I_BIT];
			CRF_CND_UNMASKED: r = ~cc[CRF_I_BIT];
			CRF_CND_NEG: r = cc[CRF_N_BIT];
			CRF_CND_POS: r = ~cc[CRF_N_BIT];
			CRF_CND_EQ: r = cc[CRF_Z_BIT];
			CRF_CND_NE: r = ~cc[CRF_Z_BIT];
			CRF_CND_CARRY: r = cc[CRF_C_BIT];
			CRF_CND_NO_CARRY: r = ~cc[CRF_C_BIT];
			default: r = 1'b1;
		endcase
		return r;
	endfunction

	// flags byte as seen by software, top bits forced high
	assign cc_w = CRF_CC_ONES | {3'h0, half_q, mask_q, neg_q, zero_q, carry_q};
	assign pc_w = {pch_q, pcl_q};
	assign pc_inc = pc_w + 16'h0001;
	assign acc_ok = i_cmd.valid & ~busy_q;
	assign is_alu = acc_ok & (i_cmd.op == CRF_OP_ALU);
	assign cond_ok = crf_test(i_cmd.cond, cc_w);
	// the left operand is the destination register, or the accumulator when the destination is none
	assign alu_src = (i_cmd.dst == CRF_DST_X) ? x_q : (i_cmd.dst == CRF_DST_Y) ? y_q : acc_q;

	crf_alu u_alu (
		.i_op(i_cmd.alu),
		.i_a(alu_src),
		.i_b(i_cmd.operand),
		.i_carry(carry_q),
		.o_out(alu_o)
	);

	// ****************************************
	// interrupt acceptance
	// ****************************************
	// entry only starts at a command boundary; trap ignores the mask
	assign take_trap = ~busy_q & ~i_cmd.valid & trap_pend_q;
	assign take_any = take_trap | (~busy_q & ~i_cmd.valid & irq_pend_q & ~mask_q);
	assign start_push = take_any;
	assign start_pop = acc_ok & (i_cmd.op == CRF_OP_INTERRUPT_RETURN_INSTR);

	crf_ctx_seq u_seq (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_start_push(start_push),
		.i_start_pop(start_pop),
		.o_wr(seq_wr),
		.o_rd(seq_rd),
		.o_idx(seq_idx)
	);

	// ****************************************
	// stack traffic
	// ****************************************
	// read data returns one cycle after the read strobe leaves the block
	assign push_done = seq_wr & (seq_idx == CRF_CTX_CC);
	assign rd_req = seq_rd | (acc_ok & (i_cmd.op == CRF_OP_POP_CC));
	assign rd_idx = seq_rd ? seq_idx : CRF_CTX_CC;
	assign ld_any = rd_act_q;
	assign ld_cc = rd_act_q & (ld_idx_q == CRF_CTX_CC);
	assign pop_done = rd_act_q & (~interrupt_return_instr_q | (ld_idx_q == CRF_CTX_PCL));
	assign stk_wr = seq_wr | (acc_ok & (i_cmd.op == CRF_OP_PUSH_CC));
	// the second index register has no slot in the context frame
	assign stk_wdata = !seq_wr ? cc_w :
		(seq_idx == CRF_CTX_PCL) ? pcl_q :
		(seq_idx == CRF_CTX_PCH) ? pch_q :
		(seq_idx == CRF_CTX_X) ? x_q :
		(seq_idx == CRF_CTX_A) ? acc_q : cc_w;

	// ****************************************
	// control flops with reset
	// ****************************************
	// a request landing on the clear cycle wins and stays pending
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mask_q <= CRF_MASK_RST;
			irq_pend_q <= 1'b0;
			trap_pend_q <= 1'b0;
			busy_q <= 1'b0;
			interrupt_return_instr_q <= 1'b0;
			rd_act_q <= 1'b0;
			rd_idx_q <= 3'h0;
			ld_idx_q <= 3'h0;
			o_taken_q <= 1'b0;
			o_irq_enter_q <= 1'b0;
			o_trap_enter_q <= 1'b0;
			o_stk_wr_q <= 1'b0;
			o_stk_rd_q <= 1'b0;
			o_stk_wdata_q <= 8'h00;
		end else begin
			irq_pend_q <= i_irq_req | (irq_pend_q & ~(take_any & ~take_trap));
			trap_pend_q <= i_trap_req | (trap_pend_q & ~take_trap);
			if (start_push | start_pop | (acc_ok & (i_cmd.op == CRF_OP_POP_CC))) begin
				busy_q <= 1'b1;
			end else if (push_done | pop_done) begin
				busy_q <= 1'b0;
			end
			if (start_pop) begin
				interrupt_return_instr_q <= 1'b1;
			end else if (acc_ok & (i_cmd.op == CRF_OP_POP_CC)) begin
				interrupt_return_instr_q <= 1'b0;
			end
			// mask: software writes first, hardware entry set has the last word
			if (ld_cc) begin
				mask_q <= interrupt_return_instr_q ? 1'b0 : i_stk_rdata[CRF_I_BIT];
			end else if (acc_ok & (i_cmd.op == CRF_OP_SET_MASK)) begin
				mask_q <= 1'b1;
			end else if (acc_ok & (i_cmd.op == CRF_OP_CLR_MASK)) begin
				mask_q <= 1'b0;
			end else if (acc_ok & (i_cmd.op == CRF_OP_CC_BIT)
				& (i_cmd.operand[2:0] == 3'(CRF_I_BIT))) begin
				mask_q <= i_cmd.bit_val;
			end
			if (push_done) begin
				mask_q <= 1'b1;
			end
			rd_act_q <= o_stk_rd_q; // load lands the cycle after the strobe, with its byte
			rd_idx_q <= rd_idx;
			ld_idx_q <= rd_idx_q;
			o_stk_rd_q <= rd_req;
			o_stk_wr_q <= stk_wr;
			o_stk_wdata_q <= stk_wdata;
			o_irq_enter_q <= take_any & ~take_trap;
			o_trap_enter_q <= take_trap;
			o_taken_q <= acc_ok & (((i_cmd.op == CRF_OP_JUMP) & cond_ok)
				| ((i_cmd.op == CRF_OP_BIT_BRANCH) & i_cmd.bit_val));
		end
	end

	// ****************************************
	// data registers and result flags, unreset
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (is_alu & (i_cmd.dst == CRF_DST_A)) acc_q <= alu_o.res;
		else if (ld_any & (ld_idx_q == CRF_CTX_A) & interrupt_return_instr_q) acc_q <= i_stk_rdata;
		if (is_alu & (i_cmd.dst == CRF_DST_X)) x_q <= alu_o.res;
		else if (ld_any & (ld_idx_q == CRF_CTX_X) & interrupt_return_instr_q) x_q <= i_stk_rdata;
		if (is_alu & (i_cmd.dst == CRF_DST_Y)) y_q <= alu_o.res;
		// counter: pops, loads, taken jumps, else a step when asked
		if (ld_any & (ld_idx_q == CRF_CTX_PCL) & interrupt_return_instr_q) pcl_q <= i_stk_rdata;
		else if (ld_any & (ld_idx_q == CRF_CTX_PCH) & interrupt_return_instr_q) pch_q <= i_stk_rdata;
		else if (acc_ok & ((i_cmd.op == CRF_OP_PC_LOAD)
			| ((i_cmd.op == CRF_OP_JUMP) & cond_ok)
			| ((i_cmd.op == CRF_OP_BIT_BRANCH) & i_cmd.bit_val))) begin
			{pch_q, pcl_q} <= i_cmd.addr;
		end else if (acc_ok & (i_cmd.op == CRF_OP_PC_INC)) begin
			{pch_q, pcl_q} <= pc_inc;
		end
		if (ld_cc) begin
			{half_q, neg_q, zero_q, carry_q} <= {i_stk_rdata[CRF_H_BIT],
				i_stk_rdata[CRF_N_BIT], i_stk_rdata[CRF_Z_BIT], i_stk_rdata[CRF_C_BIT]};
		end else if (is_alu) begin
			neg_q <= alu_o.res[7];
			zero_q <= (alu_o.res == 8'h00);
			if (alu_o.half_upd) half_q <= alu_o.half;
			if (alu_o.carry_upd) carry_q <= alu_o.carry;
		end else if (acc_ok) begin
			case (i_cmd.op)
				CRF_OP_SET_CARRY: carry_q <= 1'b1;
				CRF_OP_RST_CARRY: carry_q <= 1'b0;
				CRF_OP_BIT_BRANCH: carry_q <= i_cmd.bit_val;
				CRF_OP_CC_BIT: begin
					if (i_cmd.operand[2:0] == 3'(CRF_H_BIT)) half_q <= i_cmd.bit_val;
					if (i_cmd.operand[2:0] == 3'(CRF_N_BIT)) neg_q <= i_cmd.bit_val;
					if (i_cmd.operand[2:0] == 3'(CRF_Z_BIT)) zero_q <= i_cmd.bit_val;
					if (i_cmd.operand[2:0] == 3'(CRF_C_BIT)) carry_q <= i_cmd.bit_val;
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// registers leave only through this view and stack pushes, never through a memory address
	assign o_view = {acc_q, x_q, y_q, pch_q, pcl_q, cc_w};
	assign o_busy_q = busy_q;
endmodule

// *** crf_pkg.sv ***
// constants, types and command encodings for the cpu core register file
// How it works
// - an 8-bit accumulator feeds the alu and takes its results.
// - two 8-bit index registers; the second is chosen by the command's destination field.
// - interrupt entry and return never save or restore the second index register.
// - a 16-bit program counter made of a low byte and a high byte.
// - the registers have no memory address; only commands reach them.
// - flags register top three bits read one; reset sets the mask bit.
// - flags register can be pushed to and popped from the stack.
// - add and add-with-carry set half carry from a bit 3 carry, else clear it.
// - hardware sets the mask bit when interrupt entry runs.
// - mask one blocks maskable requests; only the software trap still enters.
// - set-mask, clear-mask and return commands drive the mask; mask jumps test it.
// - requests arriving while masked stay pending until the mask clears.
// - interrupt return clears the mask at the end of the routine.
// - clearing the mask inside a routine lets pending requests enter at once.
// - negative flag copies result bit 7 after every data operation.
// - zero flag is set when the result is zero, cleared otherwise.
// - carry flag takes the carry or borrow of add and subtract; logic, increment and decrement leave it.
// - set-carry and reset-carry commands drive carry; carry jumps test it.
// - bit test and branch, shifts and rotates also update carry.
// - each flag can be tested and written on its own by commands.
// - interrupt entry pushes counter low byte first, then high byte, x, accumulator and flags.
package crf_pkg;

	// ****************************************
	// flag positions and reset values
	// ****************************************
	localparam int unsigned CRF_C_BIT = 0;
	localparam int unsigned CRF_Z_BIT = 1;
	localparam int unsigned CRF_N_BIT = 2;
	localparam int unsigned CRF_I_BIT = 3;
	localparam int unsigned CRF_H_BIT = 4;
	localparam logic [7:0] CRF_CC_ONES = 8'hE0;
	localparam logic [2:0] CRF_CC_TOP_RST = 3'h7;
	localparam logic CRF_MASK_RST = 1'b1;

	// ****************************************
	// context order on the stack
	// ****************************************
	localparam logic [2:0] CRF_CTX_PCL = 3'h0;
	localparam logic [2:0] CRF_CTX_PCH = 3'h1;
	localparam logic [2:0] CRF_CTX_X = 3'h2;
	localparam logic [2:0] CRF_CTX_A = 3'h3;
	localparam logic [2:0] CRF_CTX_CC = 3'h4;

	typedef enum logic [3:0] {
		CRF_ALU_LD, CRF_ALU_ADD, CRF_ALU_ADC, CRF_ALU_SUB, CRF_ALU_SBC,
		CRF_ALU_AND, CRF_ALU_OR, CRF_ALU_XOR, CRF_ALU_INC, CRF_ALU_DEC,
		CRF_ALU_SLL, CRF_ALU_SRL, CRF_ALU_RLC, CRF_ALU_RRC
	} crf_alu_t;

	typedef enum logic [3:0] {
		CRF_OP_NOP, CRF_OP_ALU, CRF_OP_PC_LOAD, CRF_OP_PC_INC, CRF_OP_SET_MASK,
		CRF_OP_CLR_MASK, CRF_OP_SET_CARRY, CRF_OP_RST_CARRY, CRF_OP_PUSH_CC,
		CRF_OP_POP_CC, CRF_OP_JUMP, CRF_OP_BIT_BRANCH, CRF_OP_INTERRUPT_RETURN_INSTR, CRF_OP_CC_BIT
	} crf_op_t;

	typedef enum logic [1:0] {
		CRF_DST_A, CRF_DST_X, CRF_DST_Y, CRF_DST_NONE
	} crf_dst_t;

	// jump conditions, one true and one false polarity per flag
	typedef enum logic [3:0] {
		CRF_CND_ALWAYS, CRF_CND_HALF, CRF_CND_NO_HALF, CRF_CND_MASKED,
		CRF_CND_UNMASKED, CRF_CND_NEG, CRF_CND_POS, CRF_CND_EQ, CRF_CND_NE,
		CRF_CND_CARRY, CRF_CND_NO_CARRY
	} crf_cond_t;

	typedef struct packed {
		logic valid;
		crf_op_t op;
		crf_alu_t alu;
		crf_dst_t dst;
		logic [7:0] operand;
		logic [15:0] addr;
		crf_cond_t cond;
		logic bit_val;
	} crf_cmd_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] idx_x;
		logic [7:0] idx_y;
		logic [15:0] pc;
		logic [7:0] cc;
	} crf_view_t;

	typedef struct packed {
		logic [7:0] res;
		logic half;
		logic carry;
		logic half_upd;
		logic carry_upd;
	} crf_alu_out_t;

endpackage

// *** crf_alu.sv ***
// combinational alu producing result, half carry and carry
`timescale 1ns/1ps
module crf_alu (
	input wire crf_pkg::crf_alu_t i_op,
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	input wire logic i_carry,
	output crf_pkg::crf_alu_out_t o_out
);
	import crf_pkg::*;

	// ****************************************
	// arithmetic paths
	// ****************************************
	// a nine bit sum keeps the carry out; a five bit low sum gives the half carry
	logic cin;
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [8:0] diff;
	assign cin = (i_op == CRF_ALU_ADC) ? i_carry : 1'b0;
	assign sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
	assign low_sum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
	assign diff = {1'b0, i_a} - {1'b0, i_b} - {8'h00, (i_op == CRF_ALU_SBC) & i_carry};

	// result select, carry only moves for arithmetic, shift and rotate
	always_comb begin
		o_out = '0;
		case (i_op)
			CRF_ALU_ADD, CRF_ALU_ADC: begin
				o_out.res = sum[7:0];
				o_out.carry = sum[8];
				o_out.half = low_sum[4];
				o_out.half_upd = 1'b1;
				o_out.carry_upd = 1'b1;
			end
			CRF_ALU_SUB, CRF_ALU_SBC: begin
				o_out.res = diff[7:0];
				o_out.carry = diff[8];
				o_out.carry_upd = 1'b1;
			end
			CRF_ALU_AND: o_out.res = i_a & i_b;
			CRF_ALU_OR: o_out.res = i_a | i_b;
			CRF_ALU_XOR: o_out.res = i_a ^ i_b;
			CRF_ALU_INC: o_out.res = i_a + 8'h01;
			CRF_ALU_DEC: o_out.res = i_a - 8'h01;
			CRF_ALU_SLL: begin
				o_out.res = {i_a[6:0], 1'b0};
				o_out.carry = i_a[7];
				o_out.carry_upd = 1'b1;
			end
			CRF_ALU_SRL: begin
				o_out.res = {1'b0, i_a[7:1]};
				o_out.carry = i_a[0];
				o_out.carry_upd = 1'b1;
			end
			CRF_ALU_RLC: begin
				o_out.res = {i_a[6:0], i_carry};
				o_out.carry = i_a[7];
				o_out.carry_upd = 1'b1;
			end
			CRF_ALU_RRC: begin
				o_out.res = {i_carry, i_a[7:1]};
				o_out.carry = i_a[0];
				o_out.carry_upd = 1'b1;
			end
			default: o_out.res = i_b;
		endcase
	end
endmodule

// *** crf_ctx_seq.sv ***
// context sequencer stepping through the stack bytes of interrupt entry and return
`timescale 1ns/1ps
module crf_ctx_seq (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_start_push,
	input wire logic i_start_pop,
	output logic o_wr,
	output logic o_rd,
	output logic [2:0] o_idx
);
	import crf_pkg::*;

	typedef enum logic [1:0] {
		CRF_SEQ_IDLE, CRF_SEQ_PUSH, CRF_SEQ_POP
	} crf_seq_t;

	crf_seq_t state_q;
	crf_seq_t state_d;
	logic [2:0] idx_q;
	logic [2:0] idx_d;

	// ****************************************
	// step control
	// ****************************************
	// pushes count up from the low counter byte, pops count down from the flags
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		case (state_q)
			CRF_SEQ_IDLE: begin
				if (i_start_push) begin
					state_d = CRF_SEQ_PUSH;
					idx_d = CRF_CTX_PCL;
				end else if (i_start_pop) begin
					state_d = CRF_SEQ_POP;
					idx_d = CRF_CTX_CC;
				end
			end
			CRF_SEQ_PUSH: begin
				if (idx_q == CRF_CTX_CC) begin
					state_d = CRF_SEQ_IDLE;
				end else begin
					idx_d = idx_q + 3'h1;
				end
			end
			default: begin
				if (idx_q == CRF_CTX_PCL) begin
					state_d = CRF_SEQ_IDLE;
				end else begin
					idx_d = idx_q - 3'h1;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= CRF_SEQ_IDLE;
			idx_q <= 3'h0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
		end
	end

	assign o_wr = (state_q == CRF_SEQ_PUSH);
	assign o_rd = (state_q == CRF_SEQ_POP);
	assign o_idx = idx_q;
endmodule

// *** crf_regs_asserts.sv ***
// concurrent checks on the ports of the register file
`timescale 1ns/1ps
module crf_regs_asserts (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire crf_pkg::crf_cmd_t i_cmd,
	input wire logic i_irq_req,
	input wire logic i_trap_req,
	input wire logic [7:0] i_stk_rdata,
	input wire crf_pkg::crf_view_t o_view,
	input wire logic o_busy_q,
	input wire logic o_taken_q,
	input wire logic o_irq_enter_q,
	input wire logic o_trap_enter_q,
	input wire logic o_stk_wr_q,
	input wire logic o_stk_rd_q,
	input wire logic [7:0] o_stk_wdata_q
);
	import crf_pkg::*;
	// a command only counts while no stack sequence runs
	wire take = i_cmd.valid && !o_busy_q;
	wire alu_a = take && i_cmd.op == CRF_OP_ALU && i_cmd.dst == CRF_DST_A;
	wire enter = o_irq_enter_q || o_trap_enter_q;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// ********
	// flags
	// ********
	cc_top_ones_a: assert property (o_view.cc[7:5] == CRF_CC_TOP_RST)
		else $error("flags top bits not one");
	half_carry_a: assert property (alu_a && i_cmd.alu == CRF_ALU_ADD |=> o_view.cc[CRF_H_BIT] ==
		(5'($past(o_view.acc[3:0])) + 5'($past(i_cmd.operand[3:0])) > 5'h0F))
		else $error("half carry wrong after add");
	neg_zero_a: assert property (alu_a |=> o_view.cc[CRF_N_BIT] == o_view.acc[7] &&
		o_view.cc[CRF_Z_BIT] == (o_view.acc == 8'h00)) else $error("negative or zero flag wrong");
	carry_cmd_a: assert property (take && (i_cmd.op == CRF_OP_SET_CARRY ||
		i_cmd.op == CRF_OP_RST_CARRY) |=> o_view.cc[CRF_C_BIT] == $past(i_cmd.op == CRF_OP_SET_CARRY))
		else $error("carry command ignored");
	mask_cmd_a: assert property (take && (i_cmd.op == CRF_OP_SET_MASK ||
		i_cmd.op == CRF_OP_CLR_MASK) |=> o_view.cc[CRF_I_BIT] == $past(i_cmd.op == CRF_OP_SET_MASK))
		else $error("mask command ignored");
	jump_carry_a: assert property (take && i_cmd.op == CRF_OP_JUMP && i_cmd.cond == CRF_CND_CARRY
		|=> o_taken_q == $past(o_view.cc[CRF_C_BIT])) else $error("carry jump wrong");
	// ********
	// stack sequences
	// ********
	masked_entry_a: assert property (o_irq_enter_q |-> !$past(o_view.cc[CRF_I_BIT]))
		else $error("maskable entry while masked");
	entry_push_a: assert property (enter |=> (o_stk_wdata_q == $past(o_view.pc[7:0], 2)) ##0
		o_stk_wr_q [*5] ##1 (!o_stk_wr_q && o_view.cc[CRF_I_BIT])) else $error("entry push wrong");
	y_untouched_a: assert property (o_busy_q |=> $stable(o_view.idx_y))
		else $error("second index changed by stack sequence");
	interrupt_return_instr_unmask_a: assert property (take && i_cmd.op == CRF_OP_INTERRUPT_RETURN_INSTR |-> ##8 !o_view.cc[CRF_I_BIT])
		else $error("mask still set after return");
	pop_cc_a: assert property (take && i_cmd.op == CRF_OP_POP_CC |-> ##1 o_stk_rd_q ##2
		o_view.cc == ($past(i_stk_rdata) | CRF_CC_ONES)) else $error("flags pop wrong");
endmodule

bind crf_regs crf_regs_asserts crf_regs_asserts_inst (.i_clk(i_clk), .i_nrst(i_nrst),
	.i_cmd(i_cmd), .i_irq_req(i_irq_req), .i_trap_req(i_trap_req), .i_stk_rdata(i_stk_rdata),
	.o_view(o_view), .o_busy_q(o_busy_q), .o_taken_q(o_taken_q), .o_irq_enter_q(o_irq_enter_q),
	.o_trap_enter_q(o_trap_enter_q), .o_stk_wr_q(o_stk_wr_q), .o_stk_rd_q(o_stk_rd_q),
	.o_stk_wdata_q(o_stk_wdata_q));

// *** crf_regs_test.sv ***
// self-checking bench for the cpu core register file
`timescale 1ns/1ps
module crf_regs_test;
	import crf_pkg::*;
	localparam logic [7:0] TA [10] = '{8'h0F, 8'hF0, 8'h08, 8'h00, 8'h80, 8'h3C,
		8'h0E, 8'h81, 8'h10, 8'h5A};
	localparam logic [7:0] TB [10] = '{8'h01, 8'h10, 8'h07, 8'h01, 8'h00, 8'h0F,
		8'h01, 8'h00, 8'h0F, 8'hFF};
	localparam crf_alu_t TOP [10] = '{CRF_ALU_ADD, CRF_ALU_ADD, CRF_ALU_ADD, CRF_ALU_SUB,
		CRF_ALU_SLL, CRF_ALU_AND, CRF_ALU_ADC, CRF_ALU_RRC, CRF_ALU_SBC, CRF_ALU_XOR};
	localparam logic [7:0] ER [10] = '{8'h10, 8'h00, 8'h0F, 8'hFF, 8'h00, 8'h0C,
		8'h10, 8'h40, 8'h00, 8'hA5};
	localparam logic [9:0] EC = 10'b0010111010;
	localparam logic [6:0] EH = 7'b1000001;
	localparam logic [10:0] JT = 11'b01100101011;
	logic i_clk;
	logic i_nrst;
	crf_cmd_t i_cmd;
	logic i_irq_req;
	logic i_trap_req;
	logic [7:0] i_stk_rdata;
	crf_view_t o_view;
	logic o_busy_q, o_taken_q, o_irq_enter_q, o_trap_enter_q, o_stk_wr_q, o_stk_rd_q;
	logic [7:0] o_stk_wdata_q;
	int fails;
	int n_compared;
	int n_irq;
	int n_trap;
	logic [7:0] pushed [$];

	crf_regs crf_regs_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_cmd(i_cmd), .i_irq_req(i_irq_req),
		.i_trap_req(i_trap_req), .i_stk_rdata(i_stk_rdata), .o_view(o_view), .o_busy_q(o_busy_q),
		.o_taken_q(o_taken_q), .o_irq_enter_q(o_irq_enter_q), .o_trap_enter_q(o_trap_enter_q),
		.o_stk_wr_q(o_stk_wr_q), .o_stk_rd_q(o_stk_rd_q), .o_stk_wdata_q(o_stk_wdata_q));

	// ********
	// clock, stack reply and monitor
	// ********
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	// stack answers one cycle after each read with a new byte, so order shows in the result
	always @(posedge i_clk) begin
		if (o_stk_rd_q === 1'b1) i_stk_rdata <= i_stk_rdata + 8'h11;
		if (o_irq_enter_q === 1'b1) n_irq++;
		if (o_trap_enter_q === 1'b1) n_trap++;
		if (o_stk_wr_q === 1'b1) pushed.push_back(o_stk_wdata_q);
	end

	// ********
	// tasks
	// ********
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic send(input crf_cmd_t c);
		@(posedge i_clk);
		i_cmd <= c;
	endtask
	// holds valid low; the short wait lets the edge updates land before sampling
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge i_clk);
			i_cmd.valid <= 1'b0;
		end
		#1;
	endtask
	function automatic crf_cmd_t mk(input crf_op_t op, input crf_alu_t alu = CRF_ALU_LD,
		input logic [7:0] opd = 8'h00, input crf_dst_t dst = CRF_DST_A,
		input logic [15:0] addr = 16'h0000, input crf_cond_t cond = CRF_CND_ALWAYS,
		input logic bv = 1'b0);
		mk = '{1'b1, op, alu, dst, opd, addr, cond, bv};
	endfunction
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// watchdog far beyond the roughly 130 cycles the tests need
	initial begin
		#200000;
		fails++;
		conclude();
	end

	// ********
	// tests
	// ********
	initial begin
		fails = 0;
		n_compared = 0;
		n_irq = 0;
		n_trap = 0;
		i_nrst = 1'b0;
		i_cmd = '0;
		i_irq_req = 1'b0;
		i_trap_req = 1'b0;
		i_stk_rdata = 8'h00;
		repeat (8) @(posedge i_clk);
		#1;
		check("cc reset", o_view.cc & 8'hE8, 8'hE8);
		check("busy reset", o_busy_q, 1'b0);
		@(posedge i_clk);
		i_nrst <= 1'b1;
		// load then operate back to back; only add and add-with-carry touch half carry, and both change carry
		for (int k = 0; k < 10; k++) begin
			send(mk(CRF_OP_ALU, CRF_ALU_LD, TA[k]));
			send(mk(CRF_OP_ALU, TOP[k], TB[k]));
			idle(1);
			check("acc", o_view.acc, ER[k]);
			check("nzc", o_view.cc & 8'h07, {ER[k][7], ER[k] == 8'h00, EC[k]});
			if (k < 3 || k == 6) check("half", o_view.cc[CRF_H_BIT], EH[k]);
		end
		send(mk(CRF_OP_ALU, CRF_ALU_LD, 8'h11, CRF_DST_X));
		send(mk(CRF_OP_ALU, CRF_ALU_LD, 8'h22, CRF_DST_Y));
		send(mk(CRF_OP_PC_LOAD, , , , 16'h12FF));
		send(mk(CRF_OP_PC_INC));
		idle(1);
		check("index", {o_view.idx_x, o_view.idx_y}, 16'h1122);
		check("pc inc", o_view.pc, 16'h1300);
		// known flags: half, mask, negative and carry set, zero clear
		send(mk(CRF_OP_ALU, CRF_ALU_LD, 8'h80));
		send(mk(CRF_OP_SET_CARRY));
		send(mk(CRF_OP_CC_BIT, , 8'h04, , , , 1'b1));
		idle(1);
		check("cc bits", o_view.cc, 8'hFD);
		for (int k = 0; k < 11; k++) begin
			send(mk(CRF_OP_JUMP, , , , 16'h4000 + 16'(k), crf_cond_t'(k)));
			idle(1);
			check("taken", o_taken_q, JT[k]);
			if (JT[k]) check("jump pc", o_view.pc, 16'h4000 + 16'(k));
		end
		send(mk(CRF_OP_BIT_BRANCH, , , , 16'h6000, , 1'b0));
		idle(1);
		check("bit no branch", {o_taken_q, o_view.cc[CRF_C_BIT]}, 2'b00);
		send(mk(CRF_OP_BIT_BRANCH, , , , 16'h5000, , 1'b1));
		idle(1);
		check("bit branch", {o_taken_q, o_view.cc[CRF_C_BIT]}, 2'b11);
		check("branch pc", o_view.pc, 16'h5000);
		send(mk(CRF_OP_PUSH_CC));
		idle(1);
		check("push cc", {o_stk_wr_q, o_stk_wdata_q}, 9'h1FD);
		@(posedge i_clk);
		i_stk_rdata <= 8'hF9;
		send(mk(CRF_OP_POP_CC));
		idle(5);
		check("pop cc", o_view.cc, 8'hEA);
		// a request while masked waits; the trap gets through regardless
		pushed.delete();
		@(posedge i_clk);
		i_irq_req <= 1'b1;
		i_trap_req <= 1'b1;
		@(posedge i_clk);
		i_irq_req <= 1'b0;
		i_trap_req <= 1'b0;
		idle(12);
		check("irq masked", n_irq, 0);
		check("trap", n_trap, 1);
		check("push count", pushed.size(), 5);
		check("push pc", {pushed[0], pushed[1]}, 16'h0050);
		check("push x a cc", {pushed[2], pushed[3], pushed[4]}, 24'h1180EA);
		pushed.delete();
		send(mk(CRF_OP_CLR_MASK));
		idle(12);
		check("irq pending", n_irq, 1);
		check("push cc mask", pushed[4], 8'hE2);
		check("mask entry", o_view.cc[CRF_I_BIT], 1'b1);
		@(posedge i_clk);
		i_stk_rdata <= 8'h10;
		send(mk(CRF_OP_INTERRUPT_RETURN_INSTR));
		idle(12);
		check("interrupt_return_instr cc", o_view.cc, 8'hE1);
		check("interrupt_return_instr a x", {o_view.acc, o_view.idx_x}, 16'h3243);
		check("interrupt_return_instr pc", o_view.pc, 16'h5465);
		check("interrupt_return_instr y", o_view.idx_y, 8'h22);
		send(mk(CRF_OP_SET_MASK));
		idle(1);
		check("set mask", o_view.cc[CRF_I_BIT], 1'b1);
		// second reset in mid-run
		@(posedge i_clk);
		i_nrst <= 1'b0;
		idle(2);
		check("rerst cc", o_view.cc & 8'hE8, 8'hE8);
		@(posedge i_clk);
		i_nrst <= 1'b1;
		idle(2);
		conclude();
	end
endmodule
